// ==== src/tec_pkg.sv ====
// Purpose: shared constants of the thermal event config and trip register block
// Assumes: register pointer values come from the serial front end
// Notes:   trip values align with the temperature word, bit 2 is 0.25 degC
package tec_pkg;

    // register pointers
    localparam logic [2:0] PTR_CONFIG      = 3'h1;
    localparam logic [2:0] PTR_ALARM_UPPER = 3'h2;
    localparam logic [2:0] PTR_ALARM_LOWER = 3'h3;
    localparam logic [2:0] PTR_CRITICAL    = 3'h4;
    localparam logic [2:0] PTR_TEMPERATURE = 3'h5;

    // configuration field positions
    localparam int CFG_EVENT_MODE   = 0;
    localparam int CFG_POLARITY     = 1;
    localparam int CFG_CRIT_ONLY    = 2;
    localparam int CFG_OUT_CONTROL  = 3;
    localparam int CFG_OUT_STATUS   = 4;
    localparam int CFG_CLEAR_EVENT  = 5;
    localparam int CFG_ALARM_LOCK   = 6;
    localparam int CFG_CRIT_LOCK    = 7;
    localparam int CFG_SHUTDOWN     = 8;
    localparam int CFG_HYST_LO      = 9;
    localparam int CFG_HYST_HI      = 10;

    // trip register layout: two's complement value in 12:2, rest reads zero
    localparam int THR_MSB = 12;
    localparam int THR_LSB = 2;
    localparam logic [15:0] THR_RESET = 16'h0000;

    // temperature word: trip status bits above the 13-bit value
    localparam int TEMP_MSB       = 12;
    localparam int TEMP_BELOW_BIT = 13;
    localparam int TEMP_ABOVE_BIT = 14;
    localparam int TEMP_CRIT_BIT  = 15;

    // hysteresis codes and widths in 0.0625 degC steps
    localparam logic [1:0]  HYST_OFF   = 2'h0;
    localparam logic [1:0]  HYST_1P5   = 2'h1;
    localparam logic [1:0]  HYST_3P0   = 2'h2;
    localparam logic [1:0]  HYST_6P0   = 2'h3;
    localparam logic [13:0] HYST_W_1P5 = 14'h0018;
    localparam logic [13:0] HYST_W_3P0 = 14'h0030;
    localparam logic [13:0] HYST_W_6P0 = 14'h0060;

endpackage : tec_pkg

// ==== src/tec_thr_reg.sv ====
// Purpose: one lockable trip point register
// Assumes: wr_en is a one-cycle pulse from the register port
// Notes:   only bits 12:2 exist; everything else reads as zero
`timescale 1ns/10ps
module tec_thr_reg
(
    input  wire logic        clk_sys,
    input  wire logic        reset_n,
    input  wire logic        wr_en,
    input  wire logic        lock,
    input  wire logic [15:0] wdata,
    output logic      [15:0] value_q
);
    typedef struct packed
    {
        logic [tec_pkg::THR_MSB:tec_pkg::THR_LSB] thr;
    } tec_thr_state_t;

    tec_thr_state_t s_q;
    tec_thr_state_t s_d;

    always_comb
    begin
        s_d = s_q;
        // a set lock makes the trip point read-only
        if (wr_en && !lock)
        begin
            s_d.thr = wdata[tec_pkg::THR_MSB:tec_pkg::THR_LSB];
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (!reset_n)
        begin
            s_q <= tec_pkg::THR_RESET[tec_pkg::THR_MSB:tec_pkg::THR_LSB];
        end
        else
        begin
            s_q <= s_d;
        end
    end

    // reserved bits and the top three bits are not stored at all
    assign value_q = {3'h0, s_q.thr, 2'h0};

endmodule : tec_thr_reg

// ==== src/tec_event_regs.sv ====
// Purpose: configuration, trip point registers and event pin control
// Assumes: register port and temperature input are on clk_sys
// Notes:   event pin is open drain; oe high means the pin is pulled low
//
// Overview of operation
// - status bit shows event pin being asserted
// - status bit ignores writes
// - clear write drops latched interrupt event
// - clear ignored in comparator mode, reads 0
// - critical condition keeps event, clear refused
// - alarm lock blocks alarm trip writes
// - critical lock blocks critical trip writes
// - locks stay set until reset
// - single write sets a lock
// - shutdown disables sensing and converter
// - no events during shutdown
// - locks refuse setting shutdown, clearing allowed
// - hysteresis codes off, 1.5, 3, 6 degC
// - three trip point registers
// - upper trip is two's complement, 0.25 degC
// - reserved trip bits read zero
// - comparisons use current trip values
// - trip cause readable in temperature word
// - event mode selects comparator or interrupt
// - polarity selects active low or high
// - output control enables the event pin
// - locks freeze mode, polarity, critical-only, control
`timescale 1ns/10ps
module tec_event_regs
(
    input  wire logic        clk_sys,
    input  wire logic        reset_n,
    input  wire logic        reg_wr_en,
    input  wire logic [2:0]  reg_ptr,
    input  wire logic [15:0] reg_wdata,
    output logic      [15:0] reg_rdata,
    input  wire logic        temp_valid,
    input  wire logic [12:0] temp_in,
    output logic             sensor_shutdown,
    output logic             event_pin_o,
    output logic             event_pin_oe
);
    typedef struct packed
    {
        logic        mode;
        logic        polarity;
        logic        crit_only;
        logic        out_en;
        logic        alarm_lock;
        logic        crit_lock;
        logic        shutdown;
        logic [1:0]  hyst;
        logic        above;
        logic        below;
        logic        crit;
        logic        cond_prev;
        logic        latched;
        logic        ev;
        logic [12:0] temp;
        logic [15:0] rdata;
    } tec_state_t;

    tec_state_t s_q;
    tec_state_t s_d;

    logic [15:0]        upper_q;
    logic [15:0]        lower_q;
    logic [15:0]        crit_thr_q;
    logic               wr_cfg;
    logic               any_lock;
    logic               cond;
    logic               rise;
    logic               clear_req;
    logic signed [13:0] t_s;
    logic signed [13:0] up_s;
    logic signed [13:0] lo_s;
    logic signed [13:0] cr_s;
    logic signed [13:0] hw_s;
    logic [13:0]        hyst_w;

    assign wr_cfg   = reg_wr_en && (reg_ptr == tec_pkg::PTR_CONFIG);
    assign any_lock = s_q.alarm_lock || s_q.crit_lock;

    // upper, lower and critical trip points
    // alarm lock guards both alarm boundaries
    tec_thr_reg u_upper
    (
        .clk_sys (clk_sys),
        .reset_n (reset_n),
        .wr_en   (reg_wr_en && (reg_ptr == tec_pkg::PTR_ALARM_UPPER)),
        .lock    (s_q.alarm_lock),
        .wdata   (reg_wdata),
        .value_q (upper_q)
    );

    tec_thr_reg u_lower
    (
        .clk_sys (clk_sys),
        .reset_n (reset_n),
        .wr_en   (reg_wr_en && (reg_ptr == tec_pkg::PTR_ALARM_LOWER)),
        .lock    (s_q.alarm_lock),
        .wdata   (reg_wdata),
        .value_q (lower_q)
    );

    // critical lock guards the critical trip point
    tec_thr_reg u_crit
    (
        .clk_sys (clk_sys),
        .reset_n (reset_n),
        .wr_en   (reg_wr_en && (reg_ptr == tec_pkg::PTR_CRITICAL)),
        .lock    (s_q.crit_lock),
        .wdata   (reg_wdata),
        .value_q (crit_thr_q)
    );

    always_comb
    begin
        unique case (s_q.hyst)
            tec_pkg::HYST_OFF: hyst_w = 14'h0000;
            tec_pkg::HYST_1P5: hyst_w = tec_pkg::HYST_W_1P5;
            tec_pkg::HYST_3P0: hyst_w = tec_pkg::HYST_W_3P0;
            tec_pkg::HYST_6P0: hyst_w = tec_pkg::HYST_W_6P0;
        endcase
    end

    // trip bits 12:0 line up with the temperature word, so compare directly
    assign t_s  = $signed({temp_in[tec_pkg::TEMP_MSB], temp_in});
    assign up_s = $signed({upper_q[tec_pkg::THR_MSB], upper_q[tec_pkg::THR_MSB:0]});
    assign lo_s = $signed({lower_q[tec_pkg::THR_MSB], lower_q[tec_pkg::THR_MSB:0]});
    assign cr_s = $signed({crit_thr_q[tec_pkg::THR_MSB], crit_thr_q[tec_pkg::THR_MSB:0]});
    assign hw_s = $signed(hyst_w);

    // critical-only narrows the event to the critical trip
    assign cond      = s_q.crit_only ? s_q.crit : (s_q.above || s_q.below || s_q.crit);
    assign rise      = cond && !s_q.cond_prev;
    assign clear_req = wr_cfg && reg_wdata[tec_pkg::CFG_CLEAR_EVENT];

    always_comb
    begin
        s_d = s_q;

        if (wr_cfg)
        begin
            if (!any_lock)
            begin
                s_d.mode      = reg_wdata[tec_pkg::CFG_EVENT_MODE];
                s_d.polarity  = reg_wdata[tec_pkg::CFG_POLARITY];
                s_d.crit_only = reg_wdata[tec_pkg::CFG_CRIT_ONLY];
                s_d.out_en    = reg_wdata[tec_pkg::CFG_OUT_CONTROL];
            end
            s_d.hyst = reg_wdata[tec_pkg::CFG_HYST_HI:tec_pkg::CFG_HYST_LO];
            // one write of 1 sets a lock
            s_d.alarm_lock = s_q.alarm_lock || reg_wdata[tec_pkg::CFG_ALARM_LOCK];
            s_d.crit_lock  = s_q.crit_lock || reg_wdata[tec_pkg::CFG_CRIT_LOCK];
            // setting refused while locked, clearing always taken
            if (!reg_wdata[tec_pkg::CFG_SHUTDOWN])
            begin
                s_d.shutdown = 1'b0;
            end
            else if (!any_lock)
            begin
                s_d.shutdown = 1'b1;
            end
        end

        // every sample taken outside shutdown is checked against the trip values held now
        if (temp_valid && !s_q.shutdown)
        begin
            s_d.temp = temp_in;
            // trips fall back only once past the hysteresis band
            if (t_s > up_s)
            begin
                s_d.above = 1'b1;
            end
            else if (t_s <= up_s - hw_s)
            begin
                s_d.above = 1'b0;
            end
            if (t_s < lo_s)
            begin
                s_d.below = 1'b1;
            end
            else if (t_s >= lo_s + hw_s)
            begin
                s_d.below = 1'b0;
            end
            if (t_s >= cr_s)
            begin
                s_d.crit = 1'b1;
            end
            else if (t_s < cr_s - hw_s)
            begin
                s_d.crit = 1'b0;
            end
        end

        s_d.cond_prev = cond;

        // clear drops the interrupt latch; a new edge the same cycle wins
        // in comparator mode the clear bit does nothing
        // an active critical trip cannot be cleared
        if (s_q.mode && clear_req && !s_q.crit)
        begin
            s_d.latched = 1'b0;
        end
        if (s_q.mode && rise)
        begin
            s_d.latched = 1'b1;
        end

        // nothing can raise an event during shutdown
        if (s_q.shutdown)
        begin
            s_d.above   = 1'b0;
            s_d.below   = 1'b0;
            s_d.crit    = 1'b0;
            s_d.latched = 1'b0;
        end
        if (!s_q.mode)
        begin
            s_d.latched = 1'b0;
        end

        // comparator follows the condition, interrupt follows the latch
        // nothing leaves the pin unless output control is on
        s_d.ev = s_q.out_en && !s_q.shutdown && (s_q.mode ? s_q.latched : cond);

        // read data; status is derived, never stored from a write
        s_d.rdata = 16'h0000;
        unique case (reg_ptr)
            tec_pkg::PTR_CONFIG:
            begin
                s_d.rdata[tec_pkg::CFG_EVENT_MODE]  = s_q.mode;
                s_d.rdata[tec_pkg::CFG_POLARITY]    = s_q.polarity;
                s_d.rdata[tec_pkg::CFG_CRIT_ONLY]   = s_q.crit_only;
                s_d.rdata[tec_pkg::CFG_OUT_CONTROL] = s_q.out_en;
                s_d.rdata[tec_pkg::CFG_OUT_STATUS]  = s_q.ev;
                s_d.rdata[tec_pkg::CFG_ALARM_LOCK]  = s_q.alarm_lock;
                s_d.rdata[tec_pkg::CFG_CRIT_LOCK]   = s_q.crit_lock;
                s_d.rdata[tec_pkg::CFG_SHUTDOWN]    = s_q.shutdown;
                s_d.rdata[tec_pkg::CFG_HYST_HI:tec_pkg::CFG_HYST_LO] = s_q.hyst;
            end
            // reserved and top bits come back as zero from the trip registers
            tec_pkg::PTR_ALARM_UPPER: s_d.rdata = upper_q;
            tec_pkg::PTR_ALARM_LOWER: s_d.rdata = lower_q;
            tec_pkg::PTR_CRITICAL:    s_d.rdata = crit_thr_q;
            // trip cause sits above the temperature value
            tec_pkg::PTR_TEMPERATURE:
            begin
                s_d.rdata[tec_pkg::TEMP_MSB:0]      = s_q.temp;
                s_d.rdata[tec_pkg::TEMP_BELOW_BIT] = s_q.below;
                s_d.rdata[tec_pkg::TEMP_ABOVE_BIT] = s_q.above;
                s_d.rdata[tec_pkg::TEMP_CRIT_BIT]  = s_q.crit;
            end
            default: s_d.rdata = 16'h0000;
        endcase
    end

    always_ff @(posedge clk_sys)
    begin
        if (!reset_n)
        begin
            s_q <= '0;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign reg_rdata       = s_q.rdata;
    assign sensor_shutdown = s_q.shutdown;
    // open drain pulls low for an active-low event or an idle active-high pin
    assign event_pin_o  = 1'b0;
    assign event_pin_oe = s_q.ev ^ s_q.polarity;

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!reset_n);

    // the clearing write must not also leave interrupt mode, or the pin follows the condition
    sequence seq_clear_ok;
        s_q.mode && s_q.latched && clear_req && !s_q.crit && !rise && !s_q.shutdown
            && (reg_wdata[tec_pkg::CFG_EVENT_MODE] || any_lock);
    endsequence

    sequence seq_clear_crit;
        s_q.mode && s_q.latched && clear_req && s_q.crit && !s_q.shutdown;
    endsequence

    a_lock_sticky: assert property (s_q.alarm_lock |=> s_q.alarm_lock)
        else $error("alarm lock dropped");

    a_upper_locked: assert property (
        (reg_wr_en && reg_ptr == tec_pkg::PTR_ALARM_UPPER && s_q.alarm_lock)
        |=> $stable(upper_q))
        else $error("upper trip changed while locked");

    a_crit_locked: assert property (
        (reg_wr_en && reg_ptr == tec_pkg::PTR_CRITICAL && s_q.crit_lock)
        |=> $stable(crit_thr_q))
        else $error("critical trip changed while locked");

    a_shutdown_refused: assert property (
        (wr_cfg && any_lock && !s_q.shutdown) |=> !s_q.shutdown)
        else $error("shutdown set while locked");

    a_no_event_shutdown: assert property (s_q.shutdown |=> !s_q.ev)
        else $error("event during shutdown");

    a_cmp_follows: assert property (
        (s_q.out_en && !s_q.mode && !s_q.shutdown) |=> (s_q.ev == $past(cond)))
        else $error("comparator output wrong");

    a_clear_drops: assert property (seq_clear_ok |=> !s_q.latched ##1 !s_q.ev)
        else $error("clear did not drop event");

    a_crit_holds: assert property (seq_clear_crit |=> s_q.latched)
        else $error("clear removed critical event");

    a_clear_reads_zero: assert property (
        (reg_ptr == tec_pkg::PTR_CONFIG) |=> !reg_rdata[tec_pkg::CFG_CLEAR_EVENT])
        else $error("clear bit read back nonzero");

    a_status_read: assert property (
        (reg_ptr == tec_pkg::PTR_CONFIG)
        |=> (reg_rdata[tec_pkg::CFG_OUT_STATUS] == $past(s_q.ev)))
        else $error("status bit does not track event");

    a_thr_reserved: assert property (
        (reg_ptr == tec_pkg::PTR_ALARM_UPPER)
        |=> (reg_rdata[1:0] == 2'h0 && reg_rdata[15:13] == 3'h0))
        else $error("reserved trip bits nonzero");

endmodule : tec_event_regs

// ==== verification/tec_host_model.sv ====
// Purpose: host side of the register port, issuing writes and reads
// Assumes: inputs change at the falling edge, one write strobe per call
// Notes:   released data bus shows the inverse of the last word
`timescale 1ns/10ps
module tec_host_model
(
    input  wire logic        clk_sys,
    output logic             reg_wr_en,
    output logic      [2:0]  reg_ptr,
    output logic      [15:0] reg_wdata,
    input  wire logic [15:0] reg_rdata
);
    initial
    begin
        reg_wr_en = 1'b0;
        reg_ptr   = 3'h0;
        reg_wdata = 16'h0000;
    end

    // two idle cycles let the event pin follow the new fields
    task automatic write_reg(input logic [2:0] ptr, input logic [15:0] data);
        @(negedge clk_sys);
        reg_wr_en = 1'b1;
        reg_ptr   = ptr;
        reg_wdata = data;
        @(negedge clk_sys);
        reg_wr_en = 1'b0;
        reg_wdata = ~data;
        repeat (2) @(negedge clk_sys);
    endtask : write_reg

    task automatic read_reg(input logic [2:0] ptr, output logic [15:0] data);
        @(negedge clk_sys);
        reg_ptr = ptr;
        @(negedge clk_sys);
        data = reg_rdata;
    endtask : read_reg
endmodule : tec_host_model

// ==== verification/tb_tec_event_regs.sv ====
// Purpose: self-checking bench for the config, trip and event pin block
// Assumes: crit trip is parked at 200 degC except where a scenario moves it
// Notes:   temperatures stay positive; one sample dips below the lower trip
`timescale 1ns/10ps
module tb_tec_event_regs;
    logic        clk_sys;
    logic        reset_n;
    logic        reg_wr_en;
    logic [2:0]  reg_ptr;
    logic [15:0] reg_wdata;
    logic [15:0] reg_rdata;
    logic        temp_valid;
    logic [12:0] temp_in;
    logic        sensor_shutdown;
    logic        event_pin_o;
    logic        event_pin_oe;
    int          errors = 0;
    int          checks = 0;

    tec_event_regs dut_u (.clk_sys(clk_sys), .reset_n(reset_n), .reg_wr_en(reg_wr_en),
        .reg_ptr(reg_ptr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .temp_valid(temp_valid), .temp_in(temp_in), .sensor_shutdown(sensor_shutdown),
        .event_pin_o(event_pin_o), .event_pin_oe(event_pin_oe));

    tec_host_model host_u (.clk_sys(clk_sys), .reg_wr_en(reg_wr_en), .reg_ptr(reg_ptr),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));

    initial
    begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp)
        begin
            errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic rd_chk(input logic [2:0] ptr, input logic [15:0] exp);
        logic [15:0] rd;
        host_u.read_reg(ptr, rd);
        chk(rd, exp);
    endtask : rd_chk

    task automatic cfg_wr(input logic [15:0] data);
        host_u.write_reg(tec_pkg::PTR_CONFIG, data);
    endtask : cfg_wr

    task automatic pin_chk(input logic exp);
        chk({14'h0, event_pin_o, event_pin_oe}, {15'h0, exp});
    endtask : pin_chk

    // flags land one cycle after the sample, the pin one more
    task automatic set_temp(input logic [12:0] t);
        @(negedge clk_sys);
        temp_valid = 1'b1;
        temp_in    = t;
        @(negedge clk_sys);
        temp_valid = 1'b0;
        repeat (2) @(negedge clk_sys);
    endtask : set_temp

    task automatic t_reset_values;
        rd_chk(tec_pkg::PTR_CONFIG, 16'h0000);
        rd_chk(tec_pkg::PTR_ALARM_UPPER, 16'h0000);
        pin_chk(1'b0);
    endtask : t_reset_values

    task automatic t_trip_format;
        // trips written while event output is off
        host_u.write_reg(tec_pkg::PTR_ALARM_UPPER, 16'hffff);
        rd_chk(tec_pkg::PTR_ALARM_UPPER, 16'h1ffc);
        host_u.write_reg(tec_pkg::PTR_ALARM_UPPER, 16'h0190);
        rd_chk(tec_pkg::PTR_ALARM_UPPER, 16'h0190);
        host_u.write_reg(tec_pkg::PTR_ALARM_LOWER, 16'h0010);
        host_u.write_reg(tec_pkg::PTR_CRITICAL, 16'h0c80);
        rd_chk(tec_pkg::PTR_ALARM_LOWER, 16'h0010);
        rd_chk(tec_pkg::PTR_CRITICAL, 16'h0c80);
        host_u.write_reg(3'h7, 16'h1234);
        rd_chk(3'h7, 16'h0000);
    endtask : t_trip_format

    task automatic t_comparator;
        set_temp(13'h100);
        cfg_wr(16'h0008);
        pin_chk(1'b0);
        set_temp(13'h1e0);
        pin_chk(1'b1);
        rd_chk(tec_pkg::PTR_CONFIG, 16'h0018);
        rd_chk(tec_pkg::PTR_TEMPERATURE, 16'h41e0);
        cfg_wr(16'h0038);
        rd_chk(tec_pkg::PTR_CONFIG, 16'h0018);
        pin_chk(1'b1);
        set_temp(13'h190);
        pin_chk(1'b0);
        cfg_wr(16'h0018);
        rd_chk(tec_pkg::PTR_CONFIG, 16'h0008);
        set_temp(13'h008);
        pin_chk(1'b1);
        rd_chk(tec_pkg::PTR_TEMPERATURE, 16'h2008);
        set_temp(13'h100);
    endtask : t_comparator

    task automatic t_polarity;
        cfg_wr(16'h000a);
        pin_chk(1'b1);
        set_temp(13'h1e0);
        pin_chk(1'b0);
        set_temp(13'h100);
    endtask : t_polarity

    task automatic t_interrupt;
        cfg_wr(16'h0009);
        set_temp(13'h1e0);
        pin_chk(1'b1);
        set_temp(13'h100);
        pin_chk(1'b1);
        cfg_wr(16'h0029);
        pin_chk(1'b0);
        rd_chk(tec_pkg::PTR_CONFIG, 16'h0009);
    endtask : t_interrupt

    task automatic t_hysteresis;
        logic [12:0] w [3];
        w = '{13'h018, 13'h030, 13'h060};
        for (int i = 0; i < 3; i++)
        begin
            cfg_wr({5'h0, 2'(i + 1), 9'h008});
            set_temp(13'h1e0);
            pin_chk(1'b1);
            set_temp(13'h190 - w[i] + 13'h001);
            pin_chk(1'b1);
            set_temp(13'h190 - w[i]);
            pin_chk(1'b0);
        end
    endtask : t_hysteresis

    task automatic t_critical;
        cfg_wr(16'h0000);
        host_u.write_reg(tec_pkg::PTR_CRITICAL, 16'h0200);
        cfg_wr(16'h0009);
        set_temp(13'h240);
        pin_chk(1'b1);
        cfg_wr(16'h0029);
        pin_chk(1'b1);
        rd_chk(tec_pkg::PTR_TEMPERATURE, 16'hc240);
        set_temp(13'h100);
        cfg_wr(16'h0029);
        pin_chk(1'b0);
        cfg_wr(16'h0000);
        host_u.write_reg(tec_pkg::PTR_CRITICAL, 16'h0c80);
    endtask : t_critical

    task automatic t_crit_only;
        cfg_wr(16'h000c);
        set_temp(13'h1e0);
        pin_chk(1'b0);
        rd_chk(tec_pkg::PTR_CONFIG, 16'h000c);
        // output off while the critical trip moves
        cfg_wr(16'h0004);
        host_u.write_reg(tec_pkg::PTR_CRITICAL, 16'h01c0);
        cfg_wr(16'h000c);
        set_temp(13'h1e0);
        pin_chk(1'b1);
        set_temp(13'h100);
        pin_chk(1'b0);
        cfg_wr(16'h0000);
        host_u.write_reg(tec_pkg::PTR_CRITICAL, 16'h0c80);
    endtask : t_crit_only

    task automatic t_shutdown;
        cfg_wr(16'h0108);
        chk({15'h0, sensor_shutdown}, 16'h0001);
        set_temp(13'h1e0);
        pin_chk(1'b0);
        rd_chk(tec_pkg::PTR_CONFIG, 16'h0108);
        cfg_wr(16'h0008);
        chk({15'h0, sensor_shutdown}, 16'h0000);
        set_temp(13'h100);
    endtask : t_shutdown

    task automatic t_locks;
        cfg_wr(16'h0040);
        rd_chk(tec_pkg::PTR_CONFIG, 16'h0040);
        host_u.write_reg(tec_pkg::PTR_ALARM_UPPER, 16'h0300);
        rd_chk(tec_pkg::PTR_ALARM_UPPER, 16'h0190);
        cfg_wr(16'h010b);
        rd_chk(tec_pkg::PTR_CONFIG, 16'h0040);
        cfg_wr(16'h0000);
        rd_chk(tec_pkg::PTR_CONFIG, 16'h0040);
        cfg_wr(16'h00c0);
        host_u.write_reg(tec_pkg::PTR_CRITICAL, 16'h0300);
        rd_chk(tec_pkg::PTR_CRITICAL, 16'h0c80);
        chk({15'h0, sensor_shutdown}, 16'h0000);
        @(negedge clk_sys);
        reset_n = 1'b0;
        repeat (2) @(negedge clk_sys);
        reset_n = 1'b1;
        rd_chk(tec_pkg::PTR_CONFIG, 16'h0000);
    endtask : t_locks

    task automatic tally_and_finish;
        $display("checks=%0d errors=%0d", checks, errors);
        if (errors == 0 && checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : tally_and_finish

    initial
    begin
        reset_n    = 1'b0;
        temp_valid = 1'b0;
        temp_in    = 13'h000;
        repeat (12) @(negedge clk_sys);
        reset_n = 1'b1;
        t_reset_values();
        t_trip_format();
        t_comparator();
        t_polarity();
        t_interrupt();
        t_hysteresis();
        t_critical();
        t_crit_only();
        t_shutdown();
        t_locks();
        tally_and_finish();
    end

    // the whole run needs well under a thousand cycles
    initial
    begin
        #100000;
        errors++;
        tally_and_finish();
    end
endmodule : tb_tec_event_regs
